// ===== sss_shutter_sequencer.sv
`timescale 1ns/1ps
module sss_shutter_sequencer
(
  input wire logic clk_sys, // system clock, 250 MHz
  input wire logic rstn, // async reset, active low
  input wire logic [5:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // write byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall the master
  input wire logic external_frame_start_trigger, // frame start pin, rising edge
  output logic exposure_active_out, // frame exposing
  output logic flash_window_out, // all lines open
  output logic frame_start_out, // pulse per accepted trigger
  output logic global_reset_out, // pulse: reset all lines
  output sss_pkg::sss_evt_t line_reset_out, // pulse: reset one line
  output sss_pkg::sss_evt_t line_read_out // pulse: read one line
);
  import sss_pkg::*;

  localparam int NS = 2; // frame slots, two allow one overlap

  // software visible state
  logic [31:0] ctrl; // control bits
  logic [31:0] expo; // exposure_duration_setting
  logic [31:0] offs; // line temporal offset
  logic [31:0] lines; // region_of_interest height
  logic single_arm; // one frame allowed in single mode
  logic [31:0] frame_cnt; // accepted frames
  logic [31:0] drop_cnt; // ignored triggers
  logic [31:0] rd_mux; // read data selection

  // bus handshake
  logic req; // any request
  logic served; // second cycle of an access
  logic rd_go; // capture read data
  logic wr_go; // commit write

  // trigger synchroniser
  logic trig_s1; // first stage, only feeds trig_s2
  logic trig_s2; // synchronised level
  logic trig_q; // delayed level for edge detect
  logic trig_edge; // rising edge of trigger

  // slot interface
  logic [NS-1:0] busy; // slot running
  logic [NS-1:0] start; // slot start pulse
  logic [NS-1:0] exposing; // slot exposing
  logic [NS-1:0] all_open; // slot flash window
  logic [NS-1:0] shared; // slot past exposure phase
  logic [NS-1:0] greset; // slot global reset
  sss_evt_t rs_ev [NS]; // slot line resets
  sss_evt_t rd_ev [NS]; // slot line reads
  logic [SSS_TW-1:0] rem [NS]; // slot cycles to last read

  // frame launch
  sss_cfg_t cfg_new; // settings for next frame
  sss_mode_t mode_sel; // decoded shutter mode
  logic [SSS_LW-1:0] ln; // clamped line count
  logic [SSS_TW+SSS_LW-1:0] prod; // readout span
  logic ovl_ok; // overlap permitted now
  logic armed; // acquisition ready for a trigger
  logic can_start; // a slot can take the frame
  logic tgt; // slot that takes the frame
  logic take; // trigger accepted

  // merge new write data under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // zero durations would stack events in one cycle
  function automatic logic [SSS_TW-1:0] at_least_one(input logic [31:0] v);
    return (v == '0) ? SSS_T_ONE : v;
  endfunction

  // pick whichever slot has an event; slots never collide
  function automatic sss_evt_t evt_pick(input sss_evt_t a, input sss_evt_t b);
    return a.valid ? a : b;
  endfunction

  // avalon handshake: every access waits exactly one cycle
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !served;
  assign rd_go = avs_read && !served;
  assign wr_go = avs_write && served;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      served <= 1'b0;
    end
    else
    begin
      served <= req && !served;
    end
  end

  // read data selection, unmapped reads give zero
  always_comb
  begin
    rd_mux = '0;
    if (avs_address == SSS_A_CTRL)
    begin
      rd_mux = ctrl;
    end
    else if (avs_address == SSS_A_EXPO)
    begin
      rd_mux = expo;
    end
    else if (avs_address == SSS_A_OFFS)
    begin
      rd_mux = offs;
    end
    else if (avs_address == SSS_A_LINES)
    begin
      rd_mux = lines;
    end
    else if (avs_address == SSS_A_STAT)
    begin
      rd_mux[NS-1:0] = busy;
      rd_mux[SSS_S_EXP] = exposure_active_out;
      rd_mux[SSS_S_FLASH] = flash_window_out;
      rd_mux[SSS_S_ARM] = single_arm;
    end
    else if (avs_address == SSS_A_FCNT)
    begin
      rd_mux = frame_cnt;
    end
    else if (avs_address == SSS_A_DROP)
    begin
      rd_mux = drop_cnt;
    end
  end

  // read data register, holds until the next read
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      avs_readdata <= '0;
    end
    else if (rd_go)
    begin
      avs_readdata <= rd_mux;
    end
  end

  // configuration registers, unmapped writes dropped
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= SSS_CTRL_RST;
      expo <= SSS_EXPO_RST;
      offs <= SSS_OFFS_RST;
      lines <= SSS_LINES_RST;
    end
    else if (wr_go)
    begin
      if (avs_address == SSS_A_CTRL)
      begin
        ctrl <= be_merge(ctrl, avs_writedata, avs_byteenable);
      end
      else if (avs_address == SSS_A_EXPO)
      begin
        expo <= be_merge(expo, avs_writedata, avs_byteenable);
      end
      else if (avs_address == SSS_A_OFFS)
      begin
        offs <= be_merge(offs, avs_writedata, avs_byteenable);
      end
      else if (avs_address == SSS_A_LINES)
      begin
        lines <= be_merge(lines, avs_writedata, avs_byteenable);
      end
    end
  end

  // single frame arm: a write setting it beats the frame clearing it
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      single_arm <= 1'b0;
    end
    else if (wr_go && (avs_address == SSS_A_ARM) && avs_byteenable[0] && avs_writedata[0])
    begin
      single_arm <= 1'b1;
    end
    else if (take && !ctrl[SSS_B_CONT])
    begin
      single_arm <= 1'b0;
    end
  end

  // trigger pin: two stages before any logic looks at it
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_q <= 1'b0;
    end
    else
    begin
      trig_s1 <= external_frame_start_trigger;
      trig_s2 <= trig_s1;
      trig_q <= trig_s2;
    end
  end

  assign trig_edge = trig_s2 && !trig_q;

  // shutter variant and rolling mode decode
  assign mode_sel = ctrl[SSS_B_GLOB] ? SSS_GLOB : (ctrl[SSS_B_REL] ? SSS_REL : SSS_STAG);
  assign ln = (lines[SSS_LW-1:0] == '0) ? SSS_LINE_ONE : lines[SSS_LW-1:0];
  assign prod = (ln - SSS_LINE_ONE) * at_least_one(offs);
  assign cfg_new.mode = mode_sel;
  assign cfg_new.expo = at_least_one(expo);
  assign cfg_new.offs = at_least_one(offs);
  assign cfg_new.lines = ln;
  assign cfg_new.last = cfg_new.expo + prod[SSS_TW-1:0];

  // release mode never overlaps, single frame never overlaps
  assign ovl_ok = ctrl[SSS_B_CONT] && ctrl[SSS_B_OVL] && (mode_sel != SSS_REL);
  assign armed = ctrl[SSS_B_EN] && (ctrl[SSS_B_CONT] || single_arm);

  // slot choice; a busy slot still in its exposure phase blocks
  always_comb
  begin
    can_start = 1'b0;
    tgt = 1'b0;
    if (busy == '0)
    begin
      can_start = 1'b1;
    end
    else if (busy == 2'b01)
    begin
      // new first read must land after the old last read
      can_start = ovl_ok && shared[0] && (rem[0] < cfg_new.expo);
      tgt = 1'b1;
    end
    else if (busy == 2'b10)
    begin
      can_start = ovl_ok && shared[1] && (rem[1] < cfg_new.expo);
    end
  end

  assign take = trig_edge && armed && can_start;
  assign start = take ? (tgt ? 2'b10 : 2'b01) : 2'b00;

  // frame timelines
  genvar g;
  generate
    for (g = 0; g < NS; g++)
    begin : g_slot
      sss_frame_slot u_slot
      (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(start[g]),
        .cfg_in(cfg_new),
        .busy(busy[g]),
        .exposing(exposing[g]),
        .all_open(all_open[g]),
        .shared(shared[g]),
        .greset(greset[g]),
        .rs_ev(rs_ev[g]),
        .rd_ev(rd_ev[g]),
        .rem(rem[g])
      );
    end
  endgenerate

  // registered outputs toward the pixel array
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      exposure_active_out <= 1'b0;
      flash_window_out <= 1'b0;
      frame_start_out <= 1'b0;
      global_reset_out <= 1'b0;
      line_reset_out <= '0;
      line_read_out <= '0;
    end
    else
    begin
      exposure_active_out <= |exposing;
      flash_window_out <= |all_open;
      frame_start_out <= take;
      global_reset_out <= |greset;
      line_reset_out <= evt_pick(rs_ev[0], rs_ev[1]);
      line_read_out <= evt_pick(rd_ev[0], rd_ev[1]);
    end
  end

  // frame and ignored trigger counters
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      frame_cnt <= '0;
      drop_cnt <= '0;
    end
    else if (take)
    begin
      frame_cnt <= frame_cnt + 32'h0000_0001;
    end
    else if (trig_edge)
    begin
      drop_cnt <= drop_cnt + 32'h0000_0001;
    end
  end

  sequence s_new_req;
    req && !served;
  endsequence

  property p_bus_wait;
    @(posedge clk_sys) disable iff (!rstn)
    s_new_req |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("waitrequest not one cycle");

  property p_no_ovl;
    @(posedge clk_sys) disable iff (!rstn)
    take && !ovl_ok |-> (busy == '0);
  endproperty
  a_no_ovl: assert property (p_no_ovl) else $error("frame started during readout");

  property p_ovl_cont;
    @(posedge clk_sys) disable iff (!rstn)
    take && (busy != '0) |-> ctrl[SSS_B_CONT] && ctrl[SSS_B_OVL] && (mode_sel != SSS_REL);
  endproperty
  a_ovl_cont: assert property (p_ovl_cont) else $error("overlap outside continuous");

  property p_ignore;
    @(posedge clk_sys) disable iff (!rstn)
    trig_edge && ((busy & ~shared) != '0) |-> !take ##1 !frame_start_out;
  endproperty
  a_ignore: assert property (p_ignore) else $error("trigger taken during exposure");

  property p_expo_rise;
    @(posedge clk_sys) disable iff (!rstn)
    take |=> frame_start_out ##1 exposure_active_out;
  endproperty
  a_expo_rise: assert property (p_expo_rise) else $error("exposure active late");
endmodule // sss_shutter_sequencer

// ===== sss_pkg.sv
package sss_pkg;
  // timeline and line index widths
  localparam int SSS_TW = 32; // cycle counter width
  localparam int SSS_LW = 16; // line index width
  localparam logic [SSS_LW-1:0] SSS_LINE_ONE = 16'h0001; // one line
  localparam logic [SSS_TW-1:0] SSS_T_ONE = 32'h0000_0001; // one cycle

  // register byte offsets on the avalon slave
  localparam logic [5:0] SSS_A_CTRL = 6'h00; // control bits
  localparam logic [5:0] SSS_A_EXPO = 6'h04; // exposure_duration_setting, cycles
  localparam logic [5:0] SSS_A_OFFS = 6'h08; // line temporal offset, cycles
  localparam logic [5:0] SSS_A_LINES = 6'h0C; // region_of_interest height
  localparam logic [5:0] SSS_A_ARM = 6'h10; // single-frame arm command
  localparam logic [5:0] SSS_A_STAT = 6'h14; // live status
  localparam logic [5:0] SSS_A_FCNT = 6'h18; // frames started
  localparam logic [5:0] SSS_A_DROP = 6'h1C; // triggers ignored

  // control and status field positions
  localparam int SSS_B_EN = 0; // acquisition enable
  localparam int SSS_B_CONT = 1; // continuous, else single frame
  localparam int SSS_B_OVL = 2; // overlap_enable
  localparam int SSS_B_REL = 3; // shutter_mode_select: 1 global reset release
  localparam int SSS_B_GLOB = 4; // global shutter sensor variant
  localparam int SSS_S_EXP = 2; // status: exposure active
  localparam int SSS_S_FLASH = 3; // status: flash window
  localparam int SSS_S_ARM = 4; // status: single frame armed

  // reset values
  localparam logic [31:0] SSS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SSS_EXPO_RST = 32'h0000_0100;
  localparam logic [31:0] SSS_OFFS_RST = 32'h0000_0010;
  localparam logic [31:0] SSS_LINES_RST = 32'h0000_0008;

  // shutter behaviour of one frame
  typedef enum logic [1:0] {
    SSS_STAG = 2'b00, // line-staggered rolling
    SSS_REL = 2'b01, // global reset, staggered release
    SSS_GLOB = 2'b10 // global shutter
  } sss_mode_t;

  typedef enum logic {
    SSS_IDLE = 1'b0,
    SSS_RUN = 1'b1
  } sss_state_t;

  // settings captured at frame start
  typedef struct packed {
    sss_mode_t mode;
    logic [SSS_TW-1:0] expo;
    logic [SSS_TW-1:0] offs;
    logic [SSS_TW-1:0] last; // time of last line read
    logic [SSS_LW-1:0] lines;
  } sss_cfg_t;

  // one line event toward the pixel array
  typedef struct packed {
    logic valid;
    logic [SSS_LW-1:0] idx;
  } sss_evt_t;
endpackage

// ===== sss_frame_slot.sv
`timescale 1ns/1ps
module sss_frame_slot
(
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic start, // one-cycle frame start, only when idle
  input wire sss_pkg::sss_cfg_t cfg_in, // settings for the new frame
  output logic busy, // frame in progress
  output logic exposing, // some line of this frame exposing
  output logic all_open, // every line open at once
  output logic shared, // exposure phase over, may overlap
  output logic greset, // reset all lines pulse
  output sss_pkg::sss_evt_t rs_ev, // single line reset pulse
  output sss_pkg::sss_evt_t rd_ev, // line read pulse
  output logic [sss_pkg::SSS_TW-1:0] rem // cycles to last read
);
  import sss_pkg::*;

  sss_state_t state; // slot state
  sss_cfg_t cfg; // latched settings
  logic [SSS_TW-1:0] t; // cycles since frame start
  logic [SSS_TW-1:0] rs_t; // time of next line reset
  logic [SSS_TW-1:0] rd_t; // time of next line read
  logic [SSS_LW-1:0] rs_i; // next line to reset
  logic [SSS_LW-1:0] rd_i; // next line to read
  logic [SSS_TW-1:0] last_read_t; // helper for checks only
  logic run; // running
  logic stag; // line-staggered rolling frame
  logic last_rd; // bottom line being read

  assign run = (state == SSS_RUN);
  assign busy = run;
  assign stag = (cfg.mode == SSS_STAG);
  // staggered resets only in rolling mode
  assign rs_ev.valid = run && stag && (t == rs_t) && (rs_i < cfg.lines);
  assign rs_ev.idx = rs_i;
  // every variant reads line i at expo + i * offs
  assign rd_ev.valid = run && (t == rd_t);
  assign rd_ev.idx = rd_i;
  assign last_rd = rd_ev.valid && (rd_i == cfg.lines - SSS_LINE_ONE);
  assign greset = run && !stag && (t == '0);
  assign rem = cfg.last - t;

  // exposure, flash window and overlap readiness per mode
  always_comb
  begin
    exposing = run;
    all_open = 1'b0;
    shared = 1'b0;
    case (cfg.mode)
      SSS_GLOB:
      begin
        exposing = run && (t < cfg.expo);
        all_open = exposing;
        shared = run && (t >= cfg.expo);
      end
      SSS_REL:
      begin
        all_open = run && (t < cfg.expo);
      end
      default:
      begin
        // empty if the last reset comes in the same cycle as the first read or after it
        all_open = run && (rs_i == cfg.lines) && (rd_i == '0);
        shared = run && (rs_i == cfg.lines);
      end
    endcase
  end

  // frame timeline
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= SSS_IDLE;
      cfg <= '0;
      t <= '0;
      rs_t <= '0;
      rd_t <= '0;
      rs_i <= '0;
      rd_i <= '0;
    end
    else if (start)
    begin
      state <= SSS_RUN;
      cfg <= cfg_in;
      t <= '0;
      rs_t <= '0;
      rs_i <= '0;
      rd_t <= cfg_in.expo;
      rd_i <= '0;
    end
    else if (run)
    begin
      t <= t + SSS_T_ONE;
      if (rs_ev.valid)
      begin
        rs_i <= rs_i + SSS_LINE_ONE;
        rs_t <= rs_t + cfg.offs;
      end
      if (rd_ev.valid)
      begin
        rd_i <= rd_i + SSS_LINE_ONE;
        rd_t <= rd_t + cfg.offs;
      end
      if (last_rd)
      begin
        state <= SSS_IDLE;
      end
    end
  end

  // time of the previous read, for checks
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      last_read_t <= '0;
    end
    else if (rd_ev.valid)
    begin
      last_read_t <= t;
    end
  end

  sequence s_glob_start;
    start && (cfg_in.mode == SSS_GLOB);
  endsequence
  sequence s_stag_start;
    start && (cfg_in.mode == SSS_STAG);
  endsequence

  property p_glob_start;
    @(posedge clk_sys) disable iff (!rstn)
    s_glob_start |=> greset && exposing && all_open;
  endproperty
  a_glob_start: assert property (p_glob_start) else $error("global start wrong");

  property p_stag_start;
    @(posedge clk_sys) disable iff (!rstn)
    s_stag_start |=> rs_ev.valid && (rs_ev.idx == '0) && !greset;
  endproperty
  a_stag_start: assert property (p_stag_start) else $error("rolling start wrong");

  property p_first_read;
    @(posedge clk_sys) disable iff (!rstn)
    rd_ev.valid && (rd_i == '0) |-> (t == cfg.expo) && !exposing || (cfg.mode != SSS_GLOB);
  endproperty
  a_first_read: assert property (p_first_read) else $error("first read off");

  property p_read_step;
    @(posedge clk_sys) disable iff (!rstn)
    rd_ev.valid && (rd_i != '0) |-> (t == last_read_t + cfg.offs);
  endproperty
  a_read_step: assert property (p_read_step) else $error("read spacing off");

  property p_stag_flash;
    @(posedge clk_sys) disable iff (!rstn)
    all_open && stag |-> (t <= cfg.expo) && (t > (cfg.last - cfg.expo));
  endproperty
  a_stag_flash: assert property (p_stag_flash) else $error("flash outside window");
endmodule // sss_frame_slot

// ===== sss_pixel_array.sv
`timescale 1ns/1ps
// pixel array and trigger source; logs line events in frame time
module sss_pixel_array
(
  input wire logic clk_sys, // system clock
  input wire logic frame_start_out, // frame time zero
  input wire logic global_reset_out, // reset all lines
  input wire sss_pkg::sss_evt_t line_reset_out, // reset one line
  input wire sss_pkg::sss_evt_t line_read_out, // read one line
  input wire logic exposure_active_out, // exposing
  input wire logic flash_window_out, // flash window
  output logic trig // frame start pin, always driven
);
  import sss_pkg::*;
  int t = 0; // cycles since frame start
  int rs_t [16]; // reset time per line
  int rd_t [16]; // read time per line
  int gr_t, n_gr, ex_on, ex_off, ex_cnt, fl_on, fl_off, fl_cnt; // logs
  initial trig = 1'b0;
  // outputs are registered, so sampling at the edge sees settled values
  always @(posedge clk_sys)
  begin
    if (frame_start_out === 1'b1)
    begin
      // stale line times from an earlier frame must never pass a check
      t = 0;
      n_gr = 0;
      ex_cnt = 0;
      fl_cnt = 0;
      foreach (rd_t[i])
      begin
        rd_t[i] = -1;
        rs_t[i] = -1;
      end
    end
    else
      t = t + 1;
    if (global_reset_out === 1'b1)
    begin
      gr_t = t;
      n_gr = n_gr + 1;
    end
    if (line_reset_out.valid === 1'b1 && line_reset_out.idx < 16)
      rs_t[line_reset_out.idx] = t;
    if (line_read_out.valid === 1'b1 && line_read_out.idx < 16)
      rd_t[line_read_out.idx] = t;
    if (exposure_active_out === 1'b1)
    begin
      if (ex_cnt == 0)
        ex_on = t;
      ex_off = t;
      ex_cnt = ex_cnt + 1;
    end
    if (flash_window_out === 1'b1)
    begin
      if (fl_cnt == 0)
        fl_on = t;
      fl_off = t;
      fl_cnt = fl_cnt + 1;
    end
  end

  // one clean rising edge, long enough for the synchroniser
  task automatic fire();
    @(posedge clk_sys);
    trig <= 1'b1;
    repeat (3) @(posedge clk_sys);
    trig <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule // sss_pixel_array

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import sss_pkg::*;
  logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest; // bus and clock
  logic [5:0] avs_address; // byte address
  logic [31:0] avs_writedata, avs_readdata; // data
  logic [3:0] avs_byteenable; // lanes
  logic exposure_active_out, flash_window_out, frame_start_out, global_reset_out, trig; // pins
  sss_evt_t line_reset_out, line_read_out; // line events
  int miscompares = 0; // mismatches
  int cmp_count = 0; // comparisons

  sss_shutter_sequencer DUT (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_frame_start_trigger(trig),
    .exposure_active_out(exposure_active_out), .flash_window_out(flash_window_out),
    .frame_start_out(frame_start_out), .global_reset_out(global_reset_out),
    .line_reset_out(line_reset_out), .line_read_out(line_read_out));

  sss_pixel_array pa (.clk_sys(clk_sys), .frame_start_out(frame_start_out),
    .global_reset_out(global_reset_out), .line_reset_out(line_reset_out),
    .line_read_out(line_read_out), .exposure_active_out(exposure_active_out),
    .flash_window_out(flash_window_out), .trig(trig));

  // 250 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low at an edge
  task automatic wr(logic [5:0] a, logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    avs_write <= 1'b0;
  endtask

  task automatic rd(logic [5:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // poll status until no frame slot is busy
  task automatic idle();
    logic [31:0] v;
    do
      rd(SSS_A_STAT, v);
    while (v[1:0] !== 2'b00);
  endtask

  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one frame with timing checked against the shutter mode
  task automatic frame(logic [31:0] c, int e, int d, int n);
    bit rel;
    rel = c[3] | c[4];
    wr(SSS_A_EXPO, e);
    wr(SSS_A_OFFS, d);
    wr(SSS_A_LINES, n);
    wr(SSS_A_CTRL, c);
    pa.fire();
    idle();
    for (int i = 0; i < n; i++)
    begin
      chk("read", pa.rd_t[i], e + 1 + i * d);
      if (!rel) chk("lreset", pa.rs_t[i], 1 + i * d);
    end
    chk("greset", pa.n_gr, rel);
    if (rel) chk("greset_t", pa.gr_t, 1);
    chk("exp_on", pa.ex_on, 1);
    chk("exp_off", pa.ex_off, c[4] ? e : e + (n - 1) * d + 1);
    if (rel) chk("fl_on", pa.fl_on, 1);
    if (rel) chk("fl_off", pa.fl_off, e);
    if (!rel && (n - 1) * d >= e) chk("fl_cnt", pa.fl_cnt, 0);
    if (!rel && (n - 1) * d < e) chk("fl_on", pa.fl_on, (n - 1) * d + 2);
    if (!rel && (n - 1) * d < e) chk("fl_off", pa.fl_off, e + 1);
  endtask

  // second trigger at frame time tw; counts frames and drops
  task automatic pair(logic [31:0] c, int tw, int fr, int dr);
    logic [31:0] f0, d0, f1, d1;
    wr(SSS_A_CTRL, c);
    rd(SSS_A_FCNT, f0);
    rd(SSS_A_DROP, d0);
    wr(SSS_A_ARM, 32'h0000_0001);
    pa.fire();
    wait (pa.t >= tw);
    wr(SSS_A_ARM, 32'h0000_0001);
    pa.fire();
    idle();
    rd(SSS_A_FCNT, f1);
    rd(SSS_A_DROP, d1);
    chk("frames", f1 - f0, fr);
    chk("drops", d1 - d0, dr);
  endtask

  initial
  begin
    logic [31:0] v;
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(SSS_A_CTRL, v);
    chk("ctrl", v, SSS_CTRL_RST);
    rd(SSS_A_EXPO, v);
    chk("expo", v, SSS_EXPO_RST);
    rd(SSS_A_OFFS, v);
    chk("offs", v, SSS_OFFS_RST);
    rd(SSS_A_LINES, v);
    chk("lines", v, SSS_LINES_RST);
    rd(6'h20, v);
    chk("unmapped", v, 32'h0000_0000);
    frame(32'h0000_0003, 20, 4, 4);
    frame(32'h0000_0003, 20, 8, 4);
    frame(32'h0000_000B, 20, 4, 4);
    frame(32'h0000_0013, 20, 4, 4);
    pair(32'h0000_0017, 5, 1, 1);
    pair(32'h0000_0003, 20, 1, 1);
    pair(32'h0000_0007, 20, 2, 0);
    pair(32'h0000_0005, 20, 1, 1);
    conclude();
  end

  // about 50k cycles; the tests need well under a thousand
  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule // tb
